// >>> verilog/csf_pkg.sv
package csf_pkg;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 2;
	localparam logic [1:0] ADDR_FLAGS = 2'h0;
	localparam logic [1:0] ADDR_IRQ_STAT = 2'h1;
	localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;

	// ----------------------------------------------------------------
	// Flag register layout
	// ----------------------------------------------------------------
	localparam int BIT_C = 0;
	localparam int BIT_AC = 1;
	localparam int BIT_Z = 2;
	localparam int BIT_OV = 3;
	localparam int BIT_PDF = 4;
	localparam int BIT_TO = 5;
	localparam int BIT_CZ = 6;
	localparam int BIT_SC = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] SW_WRITE_MASK = 8'hcf;
	localparam int NIBBLE_W = 4;

	// ----------------------------------------------------------------
	// Interrupt status and mask layout
	// ----------------------------------------------------------------
	localparam int IRQ_W = 3;
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_HALT = 1;
	localparam int IRQ_OVERFLOW = 2;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD,
		OP_ADC,
		OP_SUB,
		OP_SBC,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_RLC,
		OP_RRC
	} csf_op_t;

	typedef struct packed {
		logic sc;
		logic cz;
		logic to;
		logic power_down_flag;
		logic ov;
		logic z;
		logic ac;
		logic c;
	} csf_flags_t;

	typedef struct packed {
		csf_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} csf_op_req_t;

	typedef struct packed {
		logic halt;
		logic wdt_clear;
		logic wdt_timeout;
	} csf_sys_evt_t;

	function automatic logic op_is_arith(input csf_op_t op);
		op_is_arith = (op == OP_ADD) || (op == OP_ADC) || (op == OP_SUB) || (op == OP_SBC);
	endfunction : op_is_arith

endpackage : csf_pkg

// >>> verilog/csf_flag_alu.sv
`timescale 1ns/1ps
module csf_flag_alu
	import csf_pkg::*;
(
	// Operation and current flags
	input csf_op_req_t req_in,
	input csf_flags_t flags_in,
	// Result and flags after the operation
	output logic [7:0] result_out,
	output csf_flags_t flags_out
);

	logic [7:0] opnd_b;
	logic carry_in;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic carry_into_msb;
	logic next_ov;
	logic next_z;

	// Subtraction adds the inverted operand, so carry out means no borrow.
	always_comb begin
		opnd_b = req_in.b;
		carry_in = 1'b0;
		case (req_in.op)
			OP_ADC: begin
				carry_in = flags_in.c;
			end
			OP_SUB: begin
				opnd_b = ~req_in.b;
				carry_in = 1'b1;
			end
			OP_SBC: begin
				opnd_b = ~req_in.b;
				carry_in = flags_in.c;
			end
			default: begin
			end
		endcase
	end

	assign sum = {1'b0, req_in.a} + {1'b0, opnd_b} + {8'h00, carry_in};
	assign low_sum = {1'b0, req_in.a[NIBBLE_W-1:0]} + {1'b0, opnd_b[NIBBLE_W-1:0]} + {4'h0, carry_in};
	assign carry_into_msb = req_in.a[7] ^ opnd_b[7] ^ sum[7];
	assign next_ov = carry_into_msb ^ sum[8];

	always_comb begin
		flags_out = flags_in;
		result_out = req_in.a;
		next_z = 1'b0;
		case (req_in.op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
				result_out = sum[7:0];
				next_z = (sum[7:0] == 8'h00);
				flags_out.c = sum[8];
				flags_out.ac = low_sum[NIBBLE_W];
				flags_out.z = next_z;
				flags_out.ov = next_ov;
				flags_out.sc = next_ov ^ sum[7];
				if (req_in.op == OP_SUB) begin
					flags_out.cz = next_z;
				end else if (req_in.op == OP_SBC) begin
					flags_out.cz = flags_in.cz & next_z;
				end
			end
			OP_AND: begin
				result_out = req_in.a & req_in.b;
				flags_out.z = (result_out == 8'h00);
			end
			OP_OR: begin
				result_out = req_in.a | req_in.b;
				flags_out.z = (result_out == 8'h00);
			end
			OP_XOR: begin
				result_out = req_in.a ^ req_in.b;
				flags_out.z = (result_out == 8'h00);
			end
			OP_RLC: begin
				result_out = {req_in.a[6:0], flags_in.c};
				flags_out.c = req_in.a[7];
			end
			OP_RRC: begin
				result_out = {flags_in.c, req_in.a[7:1]};
				flags_out.c = req_in.a[0];
			end
			default: begin
			end
		endcase
	end

endmodule : csf_flag_alu

// >>> verilog/csf_status_reg.sv
// What this block does
// - Carry set on addition carry out or subtraction without borrow, else cleared.
// - Rotate through carry shifts carry in and loads the bit shifted out.
// - Nibble carry set on low nibble carry out or no nibble borrow.
// - Zero flag set when an arithmetic or logic result is zero.
// - Signed range flag is carry into MSB xor carry out of MSB.
// - Power down flag cleared by reset and watchdog clear, set by halt.
// - Watchdog expired flag cleared by reset, clear or halt, set by timeout.
// - Software writes never change the watchdog expired or power down flags.
// - The other six flags are read and written like ordinary data.
// - Sign xor flag is signed range flag xor result MSB.
// - Plain subtract makes chained zero equal to its zero result.
// - Subtract with borrow ANDs chained zero with its zero result.
// - All other instructions leave chained zero unchanged.
// - Flags are never saved automatically on interrupt entry or call.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module csf_status_reg
	import csf_pkg::*;
(
	// Clock, reset and enable
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	// Execution datapath
	input wire logic op_valid_in,
	input wire csf_op_req_t op_req_in,
	output logic [DATA_W-1:0] result_out,
	output logic result_valid_out,
	output csf_flags_t flags_out,
	// System events
	input wire csf_sys_evt_t sys_evt_in,
	// Interrupt
	output logic irq_out
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [2:0] reg_select(input logic [ADDR_W-1:0] addr);
		reg_select = 3'h0;
		case (addr)
			ADDR_FLAGS: reg_select = 3'h1;
			ADDR_IRQ_STAT: reg_select = 3'h2;
			ADDR_IRQ_MASK: reg_select = 3'h4;
			default: reg_select = 3'h0;
		endcase
	endfunction : reg_select

	logic [2:0] wr_sel;
	logic [2:0] rd_sel;
	logic wr_flags;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic op_take;
	logic [DATA_W-1:0] alu_result;
	csf_flags_t alu_flags;
	csf_flags_t flags;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [DATA_W-1:0] next_rdata;

	assign wr_sel = reg_select(reg_addr_in);
	assign rd_sel = reg_select(reg_addr_in);
	assign wr_flags = ce_in && reg_wr_in && wr_sel[0];
	assign wr_irq_stat = ce_in && reg_wr_in && wr_sel[1];
	assign wr_irq_mask = ce_in && reg_wr_in && wr_sel[2];
	assign op_take = ce_in && op_valid_in;

	// ----------------------------------------------------------------
	// Flag computation
	// ----------------------------------------------------------------
	csf_flag_alu u_alu (
		.req_in(op_req_in),
		.flags_in(flags),
		.result_out(alu_result),
		.flags_out(alu_flags)
	);

	// ----------------------------------------------------------------
	// Arithmetic flags
	// ----------------------------------------------------------------
	// A write-back beats a software write in the same cycle, since both come
	// from one instruction stream and the executing result is the newer one.
	// Nothing here is pushed or restored on interrupt entry or a call.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flags.sc <= FLAGS_RESET[BIT_SC];
			flags.cz <= FLAGS_RESET[BIT_CZ];
			flags.ov <= FLAGS_RESET[BIT_OV];
			flags.z <= FLAGS_RESET[BIT_Z];
			flags.ac <= FLAGS_RESET[BIT_AC];
			flags.c <= FLAGS_RESET[BIT_C];
		end else if (op_take) begin
			flags.sc <= alu_flags.sc;
			flags.cz <= alu_flags.cz;
			flags.ov <= alu_flags.ov;
			flags.z <= alu_flags.z;
			flags.ac <= alu_flags.ac;
			flags.c <= alu_flags.c;
		end else if (wr_flags) begin
			flags.sc <= reg_wdata_in[BIT_SC];
			flags.cz <= reg_wdata_in[BIT_CZ];
			flags.ov <= reg_wdata_in[BIT_OV];
			flags.z <= reg_wdata_in[BIT_Z];
			flags.ac <= reg_wdata_in[BIT_AC];
			flags.c <= reg_wdata_in[BIT_C];
		end
	end

	// ----------------------------------------------------------------
	// System flags
	// ----------------------------------------------------------------
	// Only system events reach these two bits; the register write path
	// has no connection to them.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flags.power_down_flag <= FLAGS_RESET[BIT_PDF];
		end else if (ce_in) begin
			if (sys_evt_in.halt) begin
				flags.power_down_flag <= 1'b1;
			end else if (sys_evt_in.wdt_clear) begin
				flags.power_down_flag <= 1'b0;
			end
		end
	end

	// A timeout in the same cycle as a clear or halt still sets the flag.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flags.to <= FLAGS_RESET[BIT_TO];
		end else if (ce_in) begin
			if (sys_evt_in.wdt_timeout) begin
				flags.to <= 1'b1;
			end else if (sys_evt_in.wdt_clear || sys_evt_in.halt) begin
				flags.to <= 1'b0;
			end
		end
	end

	assign flags_out = flags;

	// ----------------------------------------------------------------
	// Result write-back
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			result_out <= 8'h00;
			result_valid_out <= 1'b0;
		end else if (ce_in) begin
			result_valid_out <= op_valid_in;
			if (op_valid_in) begin
				result_out <= alu_result;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	always_comb begin
		irq_event = 3'h0;
		irq_event[IRQ_TIMEOUT] = sys_evt_in.wdt_timeout;
		irq_event[IRQ_HALT] = sys_evt_in.halt;
		irq_event[IRQ_OVERFLOW] = op_valid_in && op_is_arith(op_req_in.op) && alu_flags.ov;
	end

	// Write one to clear; an event in the clearing cycle keeps its bit set.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_stat <= IRQ_RESET;
		end else if (ce_in) begin
			irq_stat <= (irq_stat & ~(wr_irq_stat ? reg_wdata_in[IRQ_W-1:0] : 3'h0)) | irq_event;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_mask <= IRQ_RESET;
		end else if (wr_irq_mask) begin
			irq_mask <= reg_wdata_in[IRQ_W-1:0];
		end
	end

	assign irq_out = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd_in) begin
			if (rd_sel[0]) begin
				next_rdata = flags;
			end else if (rd_sel[1]) begin
				next_rdata = {5'h00, irq_stat};
			end else if (rd_sel[2]) begin
				next_rdata = {5'h00, irq_mask};
			end
		end
	end

	// Read data holds for one enabled cycle only, then returns to zero; it keeps its value while ce_in is low.
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ce_in) begin
			reg_rdata_out <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);

	logic [8:0] chk_add_sum;
	logic chk_add_carry;
	logic chk_add_nib;
	logic chk_add_ov;
	logic chk_a_msb;
	logic chk_no_sys;

	assign chk_add_sum = {1'b0, op_req_in.a} + {1'b0, op_req_in.b};
	assign chk_add_carry = chk_add_sum[8];
	assign chk_add_nib = ({1'b0, op_req_in.a[3:0]} + {1'b0, op_req_in.b[3:0]}) > 5'h0f;
	assign chk_add_ov = (op_req_in.a[7] == op_req_in.b[7]) && (chk_add_sum[7] != op_req_in.a[7]);
	assign chk_a_msb = op_req_in.a[7];
	assign chk_no_sys = !sys_evt_in.halt && !sys_evt_in.wdt_clear && !sys_evt_in.wdt_timeout;

	chk_add_carry_out: assert property (
		(op_take && op_req_in.op == OP_ADD) |=> flags.c == $past(chk_add_carry))
		else $error("carry flag does not match addition carry out");

	chk_rotate_carry: assert property (
		(op_take && op_req_in.op == OP_RLC) |=> flags.c == $past(chk_a_msb) && result_out[0] == $past(flags.c))
		else $error("rotate through carry mismatch");

	chk_nibble_carry: assert property (
		(op_take && op_req_in.op == OP_ADD) |=> flags.ac == $past(chk_add_nib))
		else $error("nibble carry mismatch on addition");

	chk_zero_result: assert property (
		(op_take && (op_is_arith(op_req_in.op) || op_req_in.op == OP_XOR)) |=> flags.z == (result_out == 8'h00))
		else $error("zero flag disagrees with result");

	chk_signed_range: assert property (
		(op_take && op_req_in.op == OP_ADD) |=> flags.ov == $past(chk_add_ov))
		else $error("signed range flag wrong on addition");

	chk_power_down: assert property (
		(ce_in && sys_evt_in.halt) |=> flags.power_down_flag ##1 (flags.power_down_flag || $past(sys_evt_in.wdt_clear)))
		else $error("power down flag not set by halt");

	chk_watchdog_flag: assert property (
		(ce_in && !sys_evt_in.wdt_timeout && (sys_evt_in.halt || sys_evt_in.wdt_clear)) |=> !flags.to)
		else $error("watchdog expired flag not cleared");

	chk_sys_readonly: assert property (
		(wr_flags && chk_no_sys) |=> $stable(flags.to) && $stable(flags.power_down_flag))
		else $error("software write changed a system flag");

	chk_sw_write: assert property (
		(wr_flags && !op_valid_in) |=> (flags & SW_WRITE_MASK) == ($past(reg_wdata_in) & SW_WRITE_MASK))
		else $error("software write to flags lost");

	chk_sign_xor: assert property (
		(op_take && op_is_arith(op_req_in.op)) |=> flags.sc == (flags.ov ^ result_out[7]))
		else $error("sign xor flag mismatch");

	chk_cz_sub: assert property (
		(op_take && op_req_in.op == OP_SUB) |=> flags.cz == flags.z)
		else $error("chained zero differs from zero after subtract");

	chk_cz_sbc: assert property (
		(op_take && op_req_in.op == OP_SBC) |=> flags.cz == ($past(flags.cz) && flags.z))
		else $error("chained zero wrong after subtract with borrow");

	chk_cz_hold: assert property (
		(op_take && op_req_in.op != OP_SUB && op_req_in.op != OP_SBC) |=> $stable(flags.cz))
		else $error("chained zero changed by another instruction");

	chk_flags_idle: assert property (
		(!op_take && !wr_flags && chk_no_sys) |=> $stable(flags))
		else $error("flags changed with no cause");

	chk_same_edge: assert property (
		op_take |=> result_valid_out && result_out == $past(alu_result) && flags.c == $past(alu_flags.c))
		else $error("flags and result not written on the same edge");

	// ----------------------------------------------------------------
	// Subtraction, rotate, logic, interrupt, system flag, read port and enable checks
	// ----------------------------------------------------------------
	chk_sub_carry: assert property (
		(op_take && op_req_in.op == OP_SUB) |=> flags.c == ($past(op_req_in.a) >= $past(op_req_in.b)))
		else $error("carry flag wrong on subtract");

	chk_rrc_carry: assert property (
		(op_take && op_req_in.op == OP_RRC) |=> flags.c == $past(op_req_in.a[0]) && result_out[7] == $past(flags.c))
		else $error("rotate right through carry mismatch");

	chk_sub_nibble: assert property (
		(op_take && op_req_in.op == OP_SUB) |=> flags.ac == ($past(op_req_in.a[3:0]) >= $past(op_req_in.b[3:0])))
		else $error("nibble carry wrong on subtract");

	chk_logic_zero: assert property (
		(op_take && (op_req_in.op == OP_AND || op_req_in.op == OP_OR)) |=> flags.z == (result_out == 8'h00))
		else $error("zero flag wrong after logic operation");

	chk_sub_range: assert property (
		(op_take && op_req_in.op == OP_SUB) |=> flags.ov == (($past(op_req_in.a[7]) != $past(op_req_in.b[7]))
			&& (result_out[7] != $past(op_req_in.a[7]))))
		else $error("signed range flag wrong on subtract");

	chk_ovf_irq: assert property (
		(op_take && op_is_arith(op_req_in.op) && alu_flags.ov) |=> irq_stat[IRQ_OVERFLOW])
		else $error("overflow interrupt status not set");

	chk_pdf_clear: assert property (
		(ce_in && sys_evt_in.wdt_clear && !sys_evt_in.halt) |=> !flags.power_down_flag)
		else $error("power down flag not cleared by watchdog clear");

	chk_halt_irq: assert property (
		(ce_in && sys_evt_in.halt) |=> irq_stat[IRQ_HALT])
		else $error("halt interrupt status not set");

	chk_timeout_set: assert property (
		(ce_in && sys_evt_in.wdt_timeout) |=> flags.to && irq_stat[IRQ_TIMEOUT])
		else $error("timeout did not set flag and status");

	chk_rdata_flags: assert property (
		(ce_in && reg_rd_in && reg_addr_in == ADDR_FLAGS) |=> reg_rdata_out == $past(flags))
		else $error("flag read data wrong");

	chk_rdata_pulse: assert property (
		(ce_in && !reg_rd_in) |=> reg_rdata_out == 8'h00)
		else $error("read data stood longer than one cycle");

	chk_ce_freeze: assert property (
		!ce_in |=> $stable(flags) && $stable(result_out) && $stable(irq_stat) && $stable(irq_mask))
		else $error("state moved while the clock enable was low");

	chk_valid_drop: assert property (
		(ce_in && !op_valid_in) |=> !result_valid_out)
		else $error("result valid without a write-back");

	cov_add_carry: cover property (op_take && op_req_in.op == OP_ADD && chk_add_carry);
	cov_sbc_chain: cover property ((op_take && op_req_in.op == OP_SUB) ##1 (op_take && op_req_in.op == OP_SBC));
	cov_halt_wake: cover property ((ce_in && sys_evt_in.halt) ##[1:20] (ce_in && sys_evt_in.wdt_clear));
	cov_irq: cover property ($rose(irq_out));

endmodule : csf_status_reg

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import csf_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and model state
	// ----------------------------------------------------------------
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic ce_in = 1'b1;
	logic [ADDR_W-1:0] reg_addr_in = '0;
	logic [DATA_W-1:0] reg_wdata_in = '0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [DATA_W-1:0] reg_rdata_out;
	logic op_valid_in = 1'b0;
	csf_op_req_t op_req_in = '0;
	logic [DATA_W-1:0] result_out;
	logic result_valid_out;
	csf_flags_t flags_out;
	csf_sys_evt_t sys_evt_in = '0;
	logic irq_out;
	int err_count = 0;
	int n_tests = 0;
	csf_flags_t ef;
	logic [2:0] eirq;
	logic [2:0] emask;
	logic pend;
	logic [7:0] pres;

	always #10 mclk_in = ~mclk_in;

	csf_status_reg i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.op_valid_in(op_valid_in), .op_req_in(op_req_in), .result_out(result_out),
		.result_valid_out(result_valid_out), .flags_out(flags_out), .sys_evt_in(sys_evt_in), .irq_out(irq_out));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task chk_flags();
		chk(flags_out.c, ef.c);
		chk(flags_out.ac, ef.ac);
		chk(flags_out.z, ef.z);
		chk(flags_out.ov, ef.ov);
		chk(flags_out.power_down_flag, ef.power_down_flag);
		chk(flags_out.to, ef.to);
		chk(flags_out.sc, ef.sc);
		chk(flags_out.cz, ef.cz);
	endtask : chk_flags

	task report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// Reference model of one instruction write-back
	// ----------------------------------------------------------------
	task model(input csf_op_t op, input logic [7:0] a, input logic [7:0] b);
		logic [7:0] bb;
		logic ci;
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] m;
		logic ar;
		ar = (op == OP_ADD) || (op == OP_ADC) || (op == OP_SUB) || (op == OP_SBC);
		bb = (op == OP_SUB || op == OP_SBC) ? ~b : b;
		ci = (op == OP_ADD) ? 1'b0 : (op == OP_SUB) ? 1'b1 : ef.c;
		s = a + bb + ci;
		n = a[3:0] + bb[3:0] + ci;
		m = a[6:0] + bb[6:0] + ci;
		case (op)
			OP_AND: pres = a & b;
			OP_OR: pres = a | b;
			OP_XOR: pres = a ^ b;
			OP_RLC: begin
				pres = {a[6:0], ef.c};
				ef.c = a[7];
			end
			OP_RRC: begin
				pres = {ef.c, a[7:1]};
				ef.c = a[0];
			end
			default: pres = s[7:0];
		endcase
		if (op != OP_RLC && op != OP_RRC) ef.z = (pres == 8'h00);
		if (ar) begin
			ef.c = s[8];
			ef.ac = n[4];
			ef.ov = m[7] ^ s[8];
			ef.sc = ef.ov ^ pres[7];
			if (ef.ov) eirq[IRQ_OVERFLOW] = 1'b1;
		end
		if (op == OP_SUB) ef.cz = ef.z;
		if (op == OP_SBC) ef.cz = ef.cz & ef.z;
	endtask : model

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	// Each step checks the answer to the previous request, so ops can run back to back.
	task step(input logic v, input csf_op_t op, input logic [7:0] a, input logic [7:0] b);
		@(posedge mclk_in);
		op_valid_in <= v;
		op_req_in <= '{op: op, a: a, b: b};
		#1;
		if (pend) begin
			chk(result_out, pres);
			chk(result_valid_out, 8'h01);
			chk_flags();
		end else begin
			chk(result_valid_out, 8'h00);
		end
		pend = v;
		if (v) model(op, a, b);
	endtask : step

	task evt(input csf_sys_evt_t e);
		@(posedge mclk_in);
		sys_evt_in <= e;
		@(posedge mclk_in);
		sys_evt_in <= '0;
		if (e.wdt_clear) {ef.power_down_flag, ef.to} = 2'b00;
		if (e.halt) {ef.power_down_flag, ef.to, eirq[IRQ_HALT]} = 3'b101;
		if (e.wdt_timeout) {ef.to, eirq[IRQ_TIMEOUT]} = 2'b11;
		#1 chk_flags();
	endtask : evt

	task reg_write(input logic [1:0] ad, input logic [7:0] d);
		@(posedge mclk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= ad;
		reg_wdata_in <= d;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
		if (ad == ADDR_FLAGS) ef = (d & SW_WRITE_MASK) | (ef & ~SW_WRITE_MASK);
		if (ad == ADDR_IRQ_STAT) eirq = eirq & ~d[2:0];
		if (ad == ADDR_IRQ_MASK) emask = d[2:0];
		#1 chk(irq_out, {7'h00, |(eirq & emask)});
	endtask : reg_write

	task reg_read(input logic [1:0] ad, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= ad;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
		@(posedge mclk_in);
		#1 chk(reg_rdata_out, 8'h00);
	endtask : reg_read

	task do_reset(input string name);
		nrst_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		{ef, eirq, emask, pend} = 15'h0000;
		#1 chk(flags_out, FLAGS_RESET);
		chk(result_valid_out, 8'h00);
		chk(irq_out, 8'h00);
		$display("test %s done", name);
	endtask : do_reset

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge mclk_in);
		err_count++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hccf8857a));
		do_reset("reset");
		reg_read(ADDR_FLAGS, FLAGS_RESET);
		// Boundary operands, back to back, including a borrow chain.
		step(1, OP_ADD, 8'hff, 8'h01);
		step(1, OP_ADD, 8'h7f, 8'h01);
		step(1, OP_SUB, 8'h10, 8'h10);
		step(1, OP_SBC, 8'h00, 8'h00);
		step(1, OP_SBC, 8'h00, 8'h01);
		step(1, OP_SBC, 8'h00, 8'h00);
		step(1, OP_AND, 8'hf0, 8'h0f);
		step(1, OP_RLC, 8'h80, 8'h00);
		step(1, OP_RRC, 8'h01, 8'h00);
		step(1, OP_ADC, 8'h0f, 8'h00);
		step(1, OP_SUB, 8'h80, 8'h01);
		step(0, OP_NONE, 8'h00, 8'h00);
		$display("test corners done");
		for (int i = 0; i < 400; i++) begin
			step(($urandom_range(0, 4) != 0), csf_op_t'($urandom_range(1, 9)), 8'($urandom), 8'($urandom));
		end
		step(0, OP_NONE, 8'h00, 8'h00);
		$display("test random_ops done");
		// Same-cycle events: timeout beats halt, halt beats clear.
		evt(3'b100);
		evt(3'b001);
		evt(3'b010);
		evt(3'b101);
		evt(3'b110);
		$display("test system_events done");
		reg_write(ADDR_FLAGS, 8'h00);
		chk(flags_out & 8'h30, ef & 8'h30);
		evt(3'b001);
		for (int i = 0; i < 20; i++) begin
			reg_write(ADDR_FLAGS, (i == 0) ? 8'hff : 8'($urandom));
			chk(flags_out, ef);
			reg_read(ADDR_FLAGS, ef);
			step(1, csf_op_t'($urandom_range(1, 9)), 8'($urandom), 8'($urandom));
			step(0, OP_NONE, 8'h00, 8'h00);
		end
		$display("test sw_write done");
		// A write-back wins over a software write in the same cycle.
		@(posedge mclk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= ADDR_FLAGS;
		reg_wdata_in <= 8'hff;
		op_valid_in <= 1'b1;
		op_req_in <= '{op: OP_SUB, a: 8'h33, b: 8'h33};
		model(OP_SUB, 8'h33, 8'h33);
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
		op_valid_in <= 1'b0;
		#1 chk_flags();
		// Nothing moves while the clock enable is low.
		@(posedge mclk_in);
		ce_in <= 1'b0;
		op_valid_in <= 1'b1;
		op_req_in <= '{op: OP_ADD, a: 8'h01, b: 8'h01};
		sys_evt_in <= 3'b100;
		@(posedge mclk_in);
		ce_in <= 1'b1;
		op_valid_in <= 1'b0;
		sys_evt_in <= '0;
		#1 chk_flags();
		$display("test priority done");
		reg_write(ADDR_IRQ_MASK, 8'h00);
		reg_write(ADDR_IRQ_STAT, 8'h07);
		evt(3'b100);
		reg_read(ADDR_IRQ_STAT, {5'h00, eirq});
		reg_write(ADDR_IRQ_MASK, 8'h02);
		reg_write(ADDR_IRQ_STAT, 8'h02);
		evt(3'b001);
		reg_write(ADDR_IRQ_MASK, 8'h07);
		reg_write(ADDR_IRQ_STAT, 8'h07);
		step(1, OP_ADD, 8'h7f, 8'h01);
		step(0, OP_NONE, 8'h00, 8'h00);
		reg_read(ADDR_IRQ_STAT, {5'h00, eirq});
		reg_write(ADDR_IRQ_MASK, 8'h03);
		reg_read(ADDR_IRQ_MASK, 8'h03);
		reg_write(2'h3, 8'hff);
		reg_read(2'h3, 8'h00);
		$display("test interrupts done");
		evt(3'b100);
		do_reset("second_reset");
		report_and_stop();
	end

endmodule : testbench
